// ===== core/aocs_pkg.sv
// Constants and types for the Add-On general control and status register.
package aocs_pkg;
	localparam logic [7:0] AOCS_REG_OFFSET = 8'h00;
	localparam int AOCS_NV_BUSY_BIT = 31;
	localparam int AOCS_NV_OP_LSB = 29;
	localparam int AOCS_RD_FIFO_RST_BIT = 25;
	localparam int AOCS_NV_PORT_LSB = 16;
	localparam int AOCS_BIST_LSB = 12;
	localparam logic [7:0] AOCS_NV_PORT_RESET = 8'h00;
	localparam logic [3:0] AOCS_BIST_RESET = 4'h0;
	localparam logic [1:0] AOCS_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] AOCS_HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0] {
		AOCS_OP_READ = 2'h0,
		AOCS_OP_LO_ADDR = 2'h1,
		AOCS_OP_HI_ADDR = 2'h2,
		AOCS_OP_WR_DATA = 2'h3
	} aocs_nv_op_e;

	typedef enum logic [1:0] {
		AOCS_ST_IDLE = 2'b01,
		AOCS_ST_WAIT = 2'b10
	} aocs_state_e;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} aocs_nv_req_s;
endpackage : aocs_pkg

// ===== core/aocs_ahb_cap.sv
// AHB-Lite address phase capture for the single-register slave.
`timescale 1ns/1ps
module aocs_ahb_cap #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [ADDR_W-1:0] haddr,
	output logic rd_take,
	output logic wr_dphase_ff
);
	import aocs_pkg::*;

	logic nxt_wr_dphase;
	logic take;
	logic hit;

	// The register offset constant is a byte wide, so narrower addresses cannot decode it.
	if (ADDR_W < 8)
	begin : g_addr_w_check
		$error("ADDR_W must be at least 8");
	end

	always_comb
	begin
		take = hsel && hready && (htrans == AOCS_HTRANS_NONSEQ || htrans == AOCS_HTRANS_SEQ);
		hit = (haddr[ADDR_W-1:2] == (ADDR_W-2)'(AOCS_REG_OFFSET >> 2));
		rd_take = take && !hwrite && hit;
		nxt_wr_dphase = wr_dphase_ff;
		if (hready)
		begin
			nxt_wr_dphase = take && hwrite && hit;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_dphase_ff <= 1'b0;
		end
		else
		begin
			wr_dphase_ff <= nxt_wr_dphase;
		end
	end
endmodule : aocs_ahb_cap

// ===== core/aocs_top.sv
// Add-On general control and status register, low part, behind an AHB-Lite slave.
`timescale 1ns/1ps
// Function
// RQ1: Writing one to bit 25 empties the pass-thru read FIFO.
// RQ2: Bit 25 is a self-clearing write-only pulse; reads return zero.
// RQ3: Software flushes only when no PCI pass-thru access runs; test use.
// RQ4: Eight-bit nv port works with control bits 31 to 29.
// RQ5: Port byte becomes low address, high address or data per bits 30:29.
// RQ6: After a read sequence the port returns the byte read from memory.
// RQ7: Condition-code field drives self-test completion code bits 3 to 0.
// RQ8: Bits 24 and 11 to 0 read zero; writes there are ignored.
module aocs_top #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output aocs_pkg::aocs_nv_req_s nv_req,
	input wire logic nv_done,
	input wire logic [7:0] nv_rdata,
	output logic rd_fifo_flush,
	output logic [3:0] bist_code
);
	import aocs_pkg::*;

	// ****************************************
	// Bus capture
	// ****************************************
	logic rd_take;
	logic wr_dphase_ff;

	aocs_ahb_cap #(
		.ADDR_W(ADDR_W)
	) u_cap (
		.clk(clk),
		.arst_n(arst_n),
		.hsel(hsel),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.haddr(haddr),
		.rd_take(rd_take),
		.wr_dphase_ff(wr_dphase_ff)
	);

	// ****************************************
	// Register state
	// ****************************************
	aocs_state_e state_ff;
	aocs_state_e nxt_state;
	logic [1:0] op_ff;
	logic [1:0] nxt_op;
	logic [7:0] port_ff;
	logic [7:0] nxt_port;
	logic [3:0] bist_ff;
	logic [3:0] nxt_bist;
	logic flush_ff;
	logic nxt_flush;
	aocs_nv_req_s nv_ff;
	aocs_nv_req_s nxt_nv;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic ready_ff;
	logic [31:0] view;
	logic busy;
	logic wr_ok;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_port = port_ff;
		nxt_bist = bist_ff;
		nxt_flush = 1'b0; // RQ2
		nxt_nv = nv_ff;
		nxt_nv.req = 1'b0;
		wr_ok = wr_dphase_ff && hready;
		case (state_ff)
			AOCS_ST_IDLE:
			begin
				if (wr_ok)
				begin
					nxt_flush = hwdata[AOCS_RD_FIFO_RST_BIT]; // RQ1
					nxt_bist = hwdata[AOCS_BIST_LSB +: 4]; // RQ7
					nxt_port = hwdata[AOCS_NV_PORT_LSB +: 8]; // RQ4
					if (hwdata[AOCS_NV_BUSY_BIT])
					begin
						nxt_op = hwdata[AOCS_NV_OP_LSB +: 2];
						case (aocs_nv_op_e'(nxt_op))
							AOCS_OP_LO_ADDR: nxt_nv.addr[7:0] = nxt_port; // RQ5
							AOCS_OP_HI_ADDR: nxt_nv.addr[15:8] = nxt_port; // RQ5
							AOCS_OP_WR_DATA:
							begin
								nxt_nv.wdata = nxt_port; // RQ5
								nxt_nv.we = 1'b1;
								nxt_nv.req = 1'b1;
								nxt_state = AOCS_ST_WAIT;
							end
							default:
							begin
								nxt_nv.we = 1'b0;
								nxt_nv.req = 1'b1;
								nxt_state = AOCS_ST_WAIT;
							end
						endcase
					end
				end
			end
			AOCS_ST_WAIT:
			begin
				if (wr_ok)
				begin
					nxt_flush = hwdata[AOCS_RD_FIFO_RST_BIT]; // RQ1
					nxt_bist = hwdata[AOCS_BIST_LSB +: 4]; // RQ7
				end
				if (nv_done)
				begin
					if (!nv_ff.we)
					begin
						nxt_port = nv_rdata; // RQ6
					end
					nxt_state = AOCS_ST_IDLE;
				end
			end
			default:
			begin
				nxt_state = AOCS_ST_IDLE;
			end
		endcase
		busy = (nxt_state == AOCS_ST_WAIT);
		view = 32'h0000_0000; // RQ8
		view[AOCS_NV_BUSY_BIT] = busy;
		view[AOCS_NV_OP_LSB +: 2] = nxt_op;
		view[AOCS_NV_PORT_LSB +: 8] = nxt_port;
		view[AOCS_BIST_LSB +: 4] = nxt_bist;
		nxt_rdata = rd_take ? view : 32'h0000_0000;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= AOCS_ST_IDLE;
			op_ff <= 2'h0;
			port_ff <= AOCS_NV_PORT_RESET;
			bist_ff <= AOCS_BIST_RESET;
			flush_ff <= 1'b0;
			nv_ff <= '0;
			rdata_ff <= 32'h0000_0000;
			ready_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			port_ff <= nxt_port;
			bist_ff <= nxt_bist;
			flush_ff <= nxt_flush;
			nv_ff <= nxt_nv;
			rdata_ff <= nxt_rdata;
			ready_ff <= 1'b1;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hrdata = rdata_ff;
	assign hreadyout = ready_ff;
	assign hresp = 1'b0;
	assign nv_req = nv_ff;
	assign rd_fifo_flush = flush_ff; // RQ3
	assign bist_code = bist_ff; // RQ7
endmodule : aocs_top

// ===== dv/aocs_props.sv
// Checker for the control and status register.
`timescale 1ns/1ps
module aocs_props #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire aocs_pkg::aocs_nv_req_s nv_req,
	input wire logic nv_done,
	input wire logic [7:0] nv_rdata,
	input wire logic rd_fifo_flush,
	input wire logic [3:0] bist_code
);
	import aocs_pkg::*;
	logic nxt_wp, nxt_rp, wp_ff, rp_ff;
	always_comb
	begin
		nxt_rp = hsel && hready && htrans[1] && !hwrite;
		nxt_wp = hsel && hready && htrans[1] && hwrite && haddr == ADDR_W'(AOCS_REG_OFFSET);
	end
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			{wp_ff, rp_ff} <= 2'h0;
		else
			{wp_ff, rp_ff} <= {nxt_wp, nxt_rp};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_wr_go;
		wp_ff && hwdata[31] && hwdata[30:29] == 2'h3 ##1 nv_req.req;
	endsequence
	sequence s_rd_done;
		nv_done && !nv_req.we && !wp_ff ##1 !wp_ff ##1 rp_ff;
	endsequence
	a_flush_go: assert property (wp_ff && hwdata[25] |=> rd_fifo_flush) else $error("no flush");
	a_flush_once: assert property (rd_fifo_flush |=> !rd_fifo_flush) else $error("flush held");
	a_bist_load: assert property (wp_ff |=> bist_code == $past(hwdata[15:12])) else $error("bist");
	a_bist_keep: assert property (!wp_ff |=> $stable(bist_code)) else $error("bist moved");
	a_resv_zero: assert property (rp_ff |-> hrdata[25:24] == 2'h0 && hrdata[11:0] == 12'h000) else $error("resv");
	a_port_data: assert property (s_rd_done |-> hrdata[23:16] == $past(nv_rdata, 2)) else $error("port");
	a_req_cause: assert property (nv_req.req |-> $past(wp_ff && hwdata[31] && hwdata[30] == hwdata[29])) else $error("req");
	a_wr_byte: assert property (s_wr_go |-> nv_req.we && nv_req.wdata == $past(hwdata[23:16])) else $error("wbyte");
endmodule : aocs_props
bind aocs_top aocs_props #(.ADDR_W(ADDR_W)) u_props (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .hrdata, .nv_req, .nv_done, .nv_rdata, .rd_fifo_flush, .bist_code);

// ===== dv/aocs_nv_mem.sv
// Behavioural model of the external memory engine.
`timescale 1ns/1ps
module aocs_nv_mem (
	input wire logic clk,
	input wire aocs_pkg::aocs_nv_req_s nv_req,
	input wire logic [3:0] lat,
	output logic nv_done = 1'b0,
	output logic [7:0] nv_rdata = 8'h3c
);
	import aocs_pkg::*;
	int cnt = -1;
	// Outside the answer cycle the data byte toggles so a stale sample shows.
	always @(posedge clk)
	begin
		nv_done <= cnt == 0;
		nv_rdata <= cnt == 0 ? nv_req.addr[7:0] ^ nv_req.addr[15:8] : ~nv_rdata;
		cnt <= nv_req.req ? int'(lat) : cnt - int'(cnt >= 0);
	end
endmodule : aocs_nv_mem

// ===== dv/testbench.sv
// Self-checking bench for the control and status register.
`timescale 1ns/1ps
module testbench;
	import aocs_pkg::*;
	logic clk = '0, arst_n = '0, hsel = '0, hwrite = '0, rp = '0;
	logic [7:0] haddr = '0, nv_rdata, b;
	logic [1:0] htrans = '0;
	logic [31:0] hwdata = '0, hrdata, d;
	logic hreadyout, hresp, nv_done, rd_fifo_flush;
	logic [3:0] lat = '0, bist_code;
	aocs_nv_req_s nv_req;
	logic [63:0] q[$];
	int fails = 0, tests_run = 0, cyc = 0, seed = 92294;
	always #5 clk = ~clk;
	aocs_top dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .nv_req, .nv_done, .nv_rdata, .rd_fifo_flush, .bist_code);
	aocs_nv_mem nv (.clk, .nv_req, .lat, .nv_done, .nv_rdata);
	task automatic results();
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected hrdata exp %h seen %h", e, s);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= AOCS_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= w ? v : $random(seed);
		do @(posedge clk); while (!hreadyout);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		q.push_back({m, e});
		xfer(1'b0, a, '0);
	endtask : rd
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			results();
		end
		if (rp && hreadyout && q.size() > 0)
		begin
			chk(hrdata & q[0][63:32], q[0][31:0]);
			void'(q.pop_front());
		end
		rp <= hsel && hreadyout && htrans[1] && !hwrite;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h00, '1, '0);
		xfer(1'b1, 8'h04, '1);
		rd(8'h04, '1, '0);
		repeat (20)
		begin
			d = $random(seed) & 32'h7fffffff;
			xfer(1'b1, 8'h00, d);
			rd(8'h00, 32'hffffffff, d & 32'h00fff000);
		end
		for (int i = 0; i < 2; i++)
		begin
			lat <= i ? 4'h5 : 4'h0;
			b = $random(seed);
			d = $random(seed);
			xfer(1'b1, 8'h00, {8'ha0, b, 16'h0000});
			xfer(1'b1, 8'h00, {8'hc0, d[7:0], 16'h0000});
			xfer(1'b1, 8'h00, 32'h80000000);
			if (i)
			begin
				rd(8'h00, 32'h80000000, 32'h80000000);
				xfer(1'b1, 8'h00, {8'he0, 8'ha5, 16'h0000});
			end
			do @(posedge clk); while (!nv_done);
			rd(8'h00, 32'h80ff0000, {8'h00, b ^ d[7:0], 16'h0000});
			xfer(1'b1, 8'h00, {8'he0, d[15:8], 16'h0000});
			do @(posedge clk); while (!nv_done);
		end
		results();
	end
endmodule : testbench
